// file: src/dim_map.svh
`ifndef DIM_MAP_SVH
`define DIM_MAP_SVH

// Register offsets on the plain register port
`define DIM_OFS_PARALLEL_ROLE     8'h00
`define DIM_OFS_MOTOR_SW_SOURCE   8'h01
`define DIM_OFS_PANEL_LANGUAGE    8'h02
`define DIM_OFS_SLAVE_COUNT       8'h03
`define DIM_OFS_BACKLIGHT_TIMEOUT 8'h04
`define DIM_OFS_INPUT_FUNC_BASE   8'h10
`define DIM_OFS_POWER_ON_AUTORUN  8'h18
`define DIM_OFS_TERMINAL_LEVELS   8'h20
`define DIM_OFS_COMMAND_STATUS    8'h21
`define DIM_OFS_SELECT_STATUS     8'h22

// Reset values
`define DIM_RST_PARALLEL_ROLE     8'h00
`define DIM_RST_MOTOR_SW_SOURCE   8'h00
`define DIM_RST_PANEL_LANGUAGE    8'h00
`define DIM_RST_SLAVE_COUNT       8'h01
`define DIM_RST_BACKLIGHT_TIMEOUT 8'h0a
`define DIM_RST_INPUT_FUNCS       64'h00_00_08_07_06_05_02_01
`define DIM_RST_POWER_ON_AUTORUN  8'h00

// Upper limits of each setting, and the backlight lower limit
`define DIM_MAX_PARALLEL_ROLE     8'h02
`define DIM_MAX_MOTOR_SW_SOURCE   8'h01
`define DIM_MAX_PANEL_LANGUAGE    8'h01
`define DIM_MAX_SLAVE_COUNT       8'h05
`define DIM_MIN_BACKLIGHT_TIMEOUT 8'h01
`define DIM_MAX_BACKLIGHT_TIMEOUT 8'h64
`define DIM_MAX_INPUT_FUNC        8'h20
`define DIM_MAX_POWER_ON_AUTORUN  8'h01

// Timing
`define DIM_CLK_MHZ               100
`define DIM_DEBOUNCE_MS           10
`define DIM_MINUTE_S              60

`endif

// file: src/dim_pkg.sv
package dim_pkg;

   // Terminal function codes
   typedef enum logic [7:0] {
      DIM_FN_NONE        = 8'h00,
      DIM_FN_RUN_FWD     = 8'h01,
      DIM_FN_RUN_REV     = 8'h02,
      DIM_FN_ENABLE_NO   = 8'h03,
      DIM_FN_ENABLE_NC   = 8'h04,
      DIM_FN_FAULT_RESET = 8'h05,
      DIM_FN_STEP_BIT0   = 8'h06,
      DIM_FN_STEP_BIT1   = 8'h07,
      DIM_FN_STEP_BIT2   = 8'h08,
      DIM_FN_STEP_BIT3   = 8'h09,
      DIM_FN_DIR_SWITCH  = 8'h0b,
      DIM_FN_ESTOP_A_HI  = 8'h0c,
      DIM_FN_ESTOP_A_LO  = 8'h0d,
      DIM_FN_ESTOP_B_HI  = 8'h0e,
      DIM_FN_ESTOP_B_LO  = 8'h0f,
      DIM_FN_FOLLOWER    = 8'h10,
      DIM_FN_MOTOR_BIT0  = 8'h11,
      DIM_FN_MOTOR_BIT1  = 8'h12,
      DIM_FN_RECT_ONLY   = 8'h13,
      DIM_FN_LINE_CONF   = 8'h14,
      DIM_FN_COAST       = 8'h18,
      DIM_FN_TORQUE_MODE = 8'h1a,
      DIM_FN_TORQUE_ZERO = 8'h1c
   } dim_func_t;

   // Power-on run interlock
   typedef enum logic [1:0] {
      DIM_ARM_SETTLE,
      DIM_ARM_WAIT_IDLE,
      DIM_ARM_READY
   } dim_arm_t;

   // Debounce state
   typedef struct packed {
      logic        meta;
      logic        sync;
      logic [19:0] cnt;
      logic        level;
      logic        settled;
   } dim_deb_t;

   // Main block state
   typedef struct packed {
      logic [7:0]      role;
      logic [7:0]      msw_src;
      logic [7:0]      lang;
      logic [7:0]      scount;
      logic [7:0]      blt;
      logic [7:0][7:0] func;
      logic [7:0]      autorun;
      logic [7:0]      rdata;
      dim_arm_t        arm;
      logic [32:0]     tick_cnt;
      logic [6:0]      min_cnt;
      logic            bl_on;
      logic            rst_prev;
      logic            fault_rst;
      logic            run_fwd;
      logic            run_rev;
      logic            enable;
      logic [3:0]      step;
      logic            coast;
      logic            estop;
      logic            follower;
      logic [1:0]      motor;
      logic            rect_only;
      logic            line_conf;
      logic            trq_mode;
      logic            trq_zero;
   } dim_state_t;

endpackage

// file: src/dim_debounce.sv
`timescale 1ns/1ps
`include "dim_map.svh"

module dim_debounce
   import dim_pkg::*;
#(
   parameter int unsigned CYCLES = 1
)
(
   input  wire logic core_clk,   // System clock
   input  wire logic rst_sync_n, // Synchronised reset
   input  wire logic pin_raw,    // Terminal pin, asynchronous
   output logic      level,      // Filtered level
   output logic      settled     // First stable period seen
);

   localparam logic [19:0] LAST = 20'(CYCLES - 1);

   dim_deb_t st;
   dim_deb_t next_st;

   // Two flops first, then a stability counter on the second only
   always_comb
   begin
      next_st      = st;
      next_st.meta = pin_raw;
      next_st.sync = st.meta;
      if (!st.settled)
      begin
         // Until one quiet period passes the level follows the pin, so a
         // run held at power-up is seen rather than the reset value
         if (st.sync != st.level)
         begin
            next_st.cnt   = 20'h0_0000;
            next_st.level = st.sync;
         end
         else if (st.cnt == LAST)
         begin
            next_st.cnt     = 20'h0_0000;
            next_st.settled = 1'b1;
         end
         else
         begin
            next_st.cnt = st.cnt + 20'h0_0001;
         end
      end
      else if (st.sync == st.level)
      begin
         next_st.cnt = 20'h0_0000;
      end
      else if (st.cnt == LAST)
      begin
         next_st.cnt   = 20'h0_0000;
         next_st.level = st.sync;
      end
      else
      begin
         next_st.cnt = st.cnt + 20'h0_0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign level   = st.level;
   assign settled = st.settled;

endmodule

// file: src/dim_top.sv
`timescale 1ns/1ps
`include "dim_map.svh"

// Functional notes
// - Parallel role 0..2, resets to standalone
// - Motor select from terminals or fieldbus
// - Slave count 0..5, resets to one
// - Backlight off after 1..100 minute timeout
// - Eight function selectors 0..32, preset defaults
// - Power-on autorun blocked or allowed, default blocked
// - Code 0 terminal does nothing
// - Codes 1/2 command forward/reverse run
// - Enable code 3 closed, code 4 open
// - Code 5 requests fault reset like panel
// - Codes 6..9 form four-bit speed step
// - Code 24 forces coast stop while active
// - Code 11 reverses direction while active
// - Emergency stop codes 12/14 active high
// - Emergency stop codes 13/15 active low
// - Code 16 reports follower ready to master, parallel role 1 only
// - Codes 17/18 select motor 1..4, terminal motor source only
// - Code 19 inhibits switches in front-end mode
// - Code 20 confirms line contactor, front-end mode
// - Code 26 selects torque, else speed control
// - Code 28 forces torque reference zero
module dim_top
   import dim_pkg::*;
#(
   parameter int unsigned          DEBOUNCE_CYCLES =
      `DIM_DEBOUNCE_MS * 1000 * `DIM_CLK_MHZ,
   parameter longint unsigned      MINUTE_CYCLES   =
      64'(`DIM_MINUTE_S) * 64'd1000000 * 64'(`DIM_CLK_MHZ)
)
(
   input  wire logic       core_clk,                 // System clock
   input  wire logic       rst_n,                    // Async reset, active low
   input  wire logic [7:0] input_terminal,           // Terminal pins, 1 = closed
   input  wire logic [7:0] reg_addr,                 // Register address
   input  wire logic [7:0] reg_wdata,                // Write data
   input  wire logic       reg_wr,                   // Write strobe
   input  wire logic       reg_rd,                   // Read strobe
   output logic      [7:0] reg_rdata,                // Read data, next cycle
   input  wire logic [1:0] bus_motor_sel,            // Fieldbus motor select
   input  wire logic       active_front_end,         // Front-end control mode
   input  wire logic       panel_reset,              // Panel reset key level
   input  wire logic       panel_activity,           // Panel key pulse
   output logic            run_forward,              // Forward run command
   output logic            run_reverse,              // Reverse run command
   output logic            drive_enable,             // Drive enabled
   output logic            fault_reset_req,          // Fault reset pulse
   output logic      [3:0] speed_step,               // Multi-step index
   output logic            coast_stop,               // Output removed
   output logic            emergency_stop,           // Emergency stop
   output logic            follower_ready_input,     // Follower ready
   output logic      [1:0] target_motor,             // 0..3 = motor 1..4
   output logic            front_end_rectifier_only, // Switches inhibited
   output logic            line_contactor_confirm,   // Contactor closed
   output logic            torque_mode_select,       // 1 torque, 0 speed
   output logic            torque_zero,              // Torque ref forced 0
   output logic            backlight_on,             // Display backlight
   output logic      [1:0] parallel_role,            // Parallel role
   output logic      [2:0] slave_count,              // Follower count
   output logic            panel_language            // Panel language
);

   localparam logic [32:0] MIN_LAST = 33'(MINUTE_CYCLES - 64'd1);

   logic       rst_meta_n;
   logic       rst_sync_n;
   logic [7:0] level;
   logic [7:0] settled;
   dim_state_t st;
   dim_state_t next_st;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // One filter per terminal
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_term
         dim_debounce #(
            .CYCLES     (DEBOUNCE_CYCLES)
         ) u_deb (
            .core_clk   (core_clk),
            .rst_sync_n (rst_sync_n),
            .pin_raw    (input_terminal[gi]),
            .level      (level[gi]),
            .settled    (settled[gi])
         );
      end
   endgenerate

   // Decode, register file and timers
   always_comb
   begin
      logic       fwd;
      logic       rev;
      logic       dsw;
      logic       en_req;
      logic       en_ok;
      logic       rst_req;
      logic [3:0] stp;
      logic       cst;
      logic       est;
      logic       fol;
      logic [1:0] msel;
      logic       rect;
      logic       line;
      logic       tmode;
      logic       tzero;
      logic       act;
      logic [2:0] widx;
      fwd     = 1'b0;
      rev     = 1'b0;
      dsw     = 1'b0;
      en_req  = 1'b0;
      en_ok   = 1'b1;
      rst_req = 1'b0;
      stp     = 4'h0;
      cst     = 1'b0;
      est     = 1'b0;
      fol     = 1'b0;
      msel    = 2'h0;
      rect    = 1'b0;
      line    = 1'b0;
      tmode   = 1'b0;
      tzero   = 1'b0;
      act     = 1'b0;
      widx    = reg_addr[2:0];
      next_st = st;

      // Per-terminal function decode
      for (int i = 0; i < 8; i++)
      begin
         act = level[i];
         case (dim_func_t'(st.func[i]))
            DIM_FN_RUN_FWD:     fwd = fwd | act;
            DIM_FN_RUN_REV:     rev = rev | act;
            DIM_FN_ENABLE_NO:
            begin
               en_req = 1'b1;
               en_ok  = en_ok & act;
            end
            DIM_FN_ENABLE_NC:
            begin
               en_req = 1'b1;
               en_ok  = en_ok & ~act;
            end
            DIM_FN_FAULT_RESET: rst_req = rst_req | act;
            DIM_FN_STEP_BIT0:   stp[0] = stp[0] | act;
            DIM_FN_STEP_BIT1:   stp[1] = stp[1] | act;
            DIM_FN_STEP_BIT2:   stp[2] = stp[2] | act;
            DIM_FN_STEP_BIT3:   stp[3] = stp[3] | act;
            DIM_FN_DIR_SWITCH:  dsw = dsw | act;
            DIM_FN_ESTOP_A_HI,
            DIM_FN_ESTOP_B_HI:  est = est | act;
            DIM_FN_ESTOP_A_LO,
            DIM_FN_ESTOP_B_LO:  est = est | ~act;
            DIM_FN_FOLLOWER:    fol = fol | act;
            DIM_FN_MOTOR_BIT0:  msel[0] = msel[0] | act;
            DIM_FN_MOTOR_BIT1:  msel[1] = msel[1] | act;
            DIM_FN_RECT_ONLY:   rect = rect | act;
            DIM_FN_LINE_CONF:   line = line | act;
            DIM_FN_COAST:       cst = cst | act;
            DIM_FN_TORQUE_MODE: tmode = tmode | act;
            DIM_FN_TORQUE_ZERO: tzero = tzero | act;
            // Code 0 and every reserved code are ignored
            default:            act = 1'b0;
         endcase
      end

      // Power-on run interlock: a run held at power-up waits for release
      case (st.arm)
         DIM_ARM_SETTLE:
         begin
            if (&settled)
            begin
               if (st.autorun[0] || !(fwd || rev))
               begin
                  next_st.arm = DIM_ARM_READY;
               end
               else
               begin
                  next_st.arm = DIM_ARM_WAIT_IDLE;
               end
            end
         end
         DIM_ARM_WAIT_IDLE:
         begin
            if (!(fwd || rev))
            begin
               next_st.arm = DIM_ARM_READY;
            end
         end
         DIM_ARM_READY:
         begin
            next_st.arm = DIM_ARM_READY;
         end
         default:
         begin
            next_st.arm = DIM_ARM_SETTLE;
         end
      endcase

      // Run commands; both at once cancel, direction switch swaps them
      if (st.arm == DIM_ARM_READY && (fwd ^ rev))
      begin
         next_st.run_fwd = fwd ^ dsw;
         next_st.run_rev = rev ^ dsw;
      end
      else
      begin
         next_st.run_fwd = 1'b0;
         next_st.run_rev = 1'b0;
      end

      // No enable terminal assigned means always enabled
      next_st.enable    = ~en_req | en_ok;
      next_st.step      = stp;
      next_st.coast     = cst;
      next_st.estop     = est;
      next_st.follower  = fol & (st.role == 8'h01);
      next_st.motor     = st.msw_src[0] ? bus_motor_sel : msel;
      next_st.rect_only = rect & active_front_end;
      next_st.line_conf = line & active_front_end;
      next_st.trq_mode  = tmode;
      next_st.trq_zero  = tzero;

      // Fault reset from terminal or panel, one pulse per press
      next_st.rst_prev  = rst_req | panel_reset;
      next_st.fault_rst = (rst_req | panel_reset) & ~st.rst_prev;

      // Backlight minute timer, restarted by panel activity
      if (panel_activity)
      begin
         next_st.tick_cnt = 33'h0_0000_0000;
         next_st.min_cnt  = 7'h00;
         next_st.bl_on    = 1'b1;
      end
      else if (st.bl_on)
      begin
         if (st.tick_cnt == MIN_LAST)
         begin
            next_st.tick_cnt = 33'h0_0000_0000;
            next_st.min_cnt  = st.min_cnt + 7'h01;
            if ({1'b0, st.min_cnt + 7'h01} >= st.blt)
            begin
               next_st.bl_on = 1'b0;
            end
         end
         else
         begin
            next_st.tick_cnt = st.tick_cnt + 33'h0_0000_0001;
         end
      end

      // Register writes; values out of range leave the setting unchanged
      if (reg_wr)
      begin
         if (reg_addr == `DIM_OFS_PARALLEL_ROLE
             && reg_wdata <= `DIM_MAX_PARALLEL_ROLE)
         begin
            next_st.role = reg_wdata;
         end
         if (reg_addr == `DIM_OFS_MOTOR_SW_SOURCE
             && reg_wdata <= `DIM_MAX_MOTOR_SW_SOURCE)
         begin
            next_st.msw_src = reg_wdata;
         end
         if (reg_addr == `DIM_OFS_PANEL_LANGUAGE
             && reg_wdata <= `DIM_MAX_PANEL_LANGUAGE)
         begin
            next_st.lang = reg_wdata;
         end
         if (reg_addr == `DIM_OFS_SLAVE_COUNT
             && reg_wdata <= `DIM_MAX_SLAVE_COUNT)
         begin
            next_st.scount = reg_wdata;
         end
         if (reg_addr == `DIM_OFS_BACKLIGHT_TIMEOUT
             && reg_wdata >= `DIM_MIN_BACKLIGHT_TIMEOUT
             && reg_wdata <= `DIM_MAX_BACKLIGHT_TIMEOUT)
         begin
            next_st.blt = reg_wdata;
         end
         if (reg_addr[7:3] == 5'(`DIM_OFS_INPUT_FUNC_BASE >> 3)
             && reg_wdata <= `DIM_MAX_INPUT_FUNC)
         begin
            next_st.func[widx] = reg_wdata;
         end
         if (reg_addr == `DIM_OFS_POWER_ON_AUTORUN
             && reg_wdata <= `DIM_MAX_POWER_ON_AUTORUN)
         begin
            next_st.autorun = reg_wdata;
         end
      end

      // Register reads; unmapped addresses return zero
      next_st.rdata = 8'h00;
      if (reg_rd)
      begin
         if (reg_addr[7:3] == 5'(`DIM_OFS_INPUT_FUNC_BASE >> 3))
         begin
            next_st.rdata = st.func[widx];
         end
         else
         begin
            case (reg_addr)
               `DIM_OFS_PARALLEL_ROLE:     next_st.rdata = st.role;
               `DIM_OFS_MOTOR_SW_SOURCE:   next_st.rdata = st.msw_src;
               `DIM_OFS_PANEL_LANGUAGE:    next_st.rdata = st.lang;
               `DIM_OFS_SLAVE_COUNT:       next_st.rdata = st.scount;
               `DIM_OFS_BACKLIGHT_TIMEOUT: next_st.rdata = st.blt;
               `DIM_OFS_POWER_ON_AUTORUN:  next_st.rdata = st.autorun;
               `DIM_OFS_TERMINAL_LEVELS:   next_st.rdata = level;
               `DIM_OFS_COMMAND_STATUS:
                  next_st.rdata = {st.run_fwd, st.run_rev, st.enable,
                                   st.coast, st.estop, st.trq_mode,
                                   st.trq_zero, st.bl_on};
               `DIM_OFS_SELECT_STATUS:
                  next_st.rdata = {st.rect_only, st.line_conf, st.motor,
                                   st.step};
               default:                    next_st.rdata = 8'h00;
            endcase
         end
      end
   end

   // State register with documented defaults
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         st         <= '0;
         st.role    <= `DIM_RST_PARALLEL_ROLE;
         st.msw_src <= `DIM_RST_MOTOR_SW_SOURCE;
         st.lang    <= `DIM_RST_PANEL_LANGUAGE;
         st.scount  <= `DIM_RST_SLAVE_COUNT;
         st.blt     <= `DIM_RST_BACKLIGHT_TIMEOUT;
         st.func    <= `DIM_RST_INPUT_FUNCS;
         st.autorun <= `DIM_RST_POWER_ON_AUTORUN;
         st.arm     <= DIM_ARM_SETTLE;
         st.bl_on   <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign reg_rdata                = st.rdata;
   assign run_forward              = st.run_fwd;
   assign run_reverse              = st.run_rev;
   assign drive_enable             = st.enable;
   assign fault_reset_req          = st.fault_rst;
   assign speed_step               = st.step;
   assign coast_stop               = st.coast;
   assign emergency_stop           = st.estop;
   assign follower_ready_input     = st.follower;
   assign target_motor             = st.motor;
   assign front_end_rectifier_only = st.rect_only;
   assign line_contactor_confirm   = st.line_conf;
   assign torque_mode_select       = st.trq_mode;
   assign torque_zero              = st.trq_zero;
   assign backlight_on             = st.bl_on;
   assign parallel_role            = st.role[1:0];
   assign slave_count              = st.scount[2:0];
   assign panel_language           = st.lang[0];

endmodule

// file: bench/dim_top_assertions.sv
`timescale 1ns/1ps
`include "dim_map.svh"
module dim_top_assertions
#(
   parameter int unsigned     DEBOUNCE_CYCLES = 4,
   parameter longint unsigned MINUTE_CYCLES   = 10
)
(
   input wire logic       core_clk,        // Clock
   input wire logic       rst_n,           // Reset, active low
   input wire logic [7:0] reg_addr,        // Address
   input wire logic [7:0] reg_wdata,       // Write data
   input wire logic       reg_wr,          // Write strobe
   input wire logic       reg_rd,          // Read strobe
   input wire logic [7:0] reg_rdata,       // Read data
   input wire logic       panel_activity,  // Key pulse
   input wire logic       run_forward,     // Forward run
   input wire logic       run_reverse,     // Reverse run
   input wire logic       fault_reset_req, // Fault reset pulse
   input wire logic       backlight_on,    // Backlight
   input wire logic [1:0] parallel_role,   // Role field
   input wire logic [2:0] slave_count      // Follower count
);
   // One domain, so clock and reset given once
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero");
   chk_role_write: assert property (reg_wr && reg_addr == `DIM_OFS_PARALLEL_ROLE
      && reg_wdata <= 8'h02 |=> parallel_role == $past(reg_wdata[1:0]))
      else $error("role write lost");
   chk_role_refuse: assert property (reg_wr && reg_addr == `DIM_OFS_PARALLEL_ROLE
      && reg_wdata > 8'h02 |=> $stable(parallel_role))
      else $error("bad role taken");
   chk_slave_refuse: assert property (reg_wr && reg_addr == `DIM_OFS_SLAVE_COUNT
      && reg_wdata > 8'h05 |=> $stable(slave_count))
      else $error("bad count taken");
   chk_role_range: assert property (parallel_role <= 2'h2)
      else $error("role out of range");
   chk_slave_range: assert property (slave_count <= 3'h5)
      else $error("count out of range");
   chk_runs_excl: assert property (!(run_forward && run_reverse))
      else $error("both runs high");
   chk_fault_pulse: assert property (fault_reset_req |=> !fault_reset_req)
      else $error("reset pulse too long");
   chk_backlight_hold: assert property (panel_activity |=> ##1 backlight_on[*8])
      else $error("backlight dropped early");
endmodule
bind dim_top dim_top_assertions #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
   .MINUTE_CYCLES(MINUTE_CYCLES)) i_dim_top_assertions (.core_clk(core_clk),
   .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .panel_activity(panel_activity),
   .run_forward(run_forward), .run_reverse(run_reverse),
   .fault_reset_req(fault_reset_req), .backlight_on(backlight_on),
   .parallel_role(parallel_role), .slave_count(slave_count));

// file: bench/dim_field_switches.sv
`timescale 1ns/1ps
module dim_field_switches
(
   input wire logic       core_clk,      // Clock
   input wire logic [7:0] want,          // Settled switch states
   output logic     [7:0] input_terminal // Contacts seen by drive
);
   logic [7:0] last = 8'h00;
   logic [7:0] chg  = 8'h00;
   logic [1:0] bnc  = 2'h0;
   initial input_terminal = 8'h00;
   // Contacts chatter after each change, so a filter without delay misfires
   always @(posedge core_clk)
   begin
      if (want !== last)
      begin
         chg <= want ^ last;
         last <= want;
         bnc <= 2'h3;
         input_terminal <= want;
      end
      else if (bnc != 2'h0)
      begin
         bnc <= bnc - 2'h1;
         input_terminal <= input_terminal ^ chg;
      end
      else
         input_terminal <= want;
   end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
`include "dim_map.svh"
module tb;
   import dim_pkg::*;
   logic       core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, afe = 0;
   logic       p_rst = 0, p_act = 0;
   logic [7:0] want = 0, pins, reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [1:0] bms = 2'h3, tmo, pr;
   logic       rf, rr, de, fr, cs, es, fo, fe, lc, tm, tz, bl, pl;
   logic [3:0] ss;
   logic [2:0] sc;
   logic [15:0] pulses = 0;
   int         errors = 0, cmp_count = 0;
   wire [15:0] st = {rf, rr, de, cs, es, fo, fe, lc, tm, tz, ss, tmo};
   // Reset values, then boundary and refused writes {addr, data, expect}
   logic [15:0] rst_tab [14] = '{16'h0000, 16'h0100, 16'h0200, 16'h0301, 16'h040a,
      16'h1001, 16'h1102, 16'h1205, 16'h1306, 16'h1407, 16'h1508, 16'h1600,
      16'h1700, 16'h1800};
   logic [23:0] wr_tab [13] = '{24'h000300, 24'h000202, 24'h030601, 24'h030505,
      24'h04000a, 24'h04650a, 24'h046464, 24'h102101, 24'h102020, 24'h180200,
      24'h180101, 24'h010200, 24'h020200};
   // Terminal one codes {code, active, idle}
   logic [39:0] fn_tab [22] = '{40'h00_2000_2000, 40'h01_a000_2000,
      40'h02_6000_2000, 40'h03_2000_0000, 40'h04_0000_2000, 40'h05_2000_2000,
      40'h06_2004_2000, 40'h09_2020_2000, 40'h0a_2000_2000, 40'h0c_2800_2000,
      40'h0d_2000_2800, 40'h0e_2800_2000, 40'h0f_2000_2800, 40'h10_2400_2000,
      40'h11_2001_2000, 40'h12_2002_2000, 40'h13_2200_2000, 40'h14_2100_2000,
      40'h18_3000_2000, 40'h1a_2080_2000, 40'h1c_2040_2000, 40'h20_2000_2000};
   always #5 core_clk = ~core_clk;
   dim_field_switches i_dim_field_switches (.core_clk(core_clk), .want(want),
      .input_terminal(pins));
   dim_top #(.DEBOUNCE_CYCLES(4), .MINUTE_CYCLES(10)) i_dim_top (.core_clk(core_clk),
      .rst_n(rst_n), .input_terminal(pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_motor_sel(bms),
      .active_front_end(afe), .panel_reset(p_rst), .panel_activity(p_act),
      .run_forward(rf), .run_reverse(rr), .drive_enable(de), .fault_reset_req(fr),
      .speed_step(ss), .coast_stop(cs), .emergency_stop(es),
      .follower_ready_input(fo), .target_motor(tmo), .front_end_rectifier_only(fe),
      .line_contactor_confirm(lc), .torque_mode_select(tm), .torque_zero(tz),
      .backlight_on(bl), .parallel_role(pr), .slave_count(sc), .panel_language(pl));
   // Fault reset pulses seen so far
   always @(posedge core_clk)
      if (fr === 1'b1)
         pulses <= pulses + 16'h1;
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         errors++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", {8'h00, reg_rdata}, {8'h00, e});
   endtask
   task automatic settle(input logic [7:0] p);
      want <= p;
      repeat (20) @(posedge core_clk);
   endtask
   task automatic test_done;
      if (errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      test_done;
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
      rd(8'h30, 8'h00);
      foreach (wr_tab[i])
      begin
         wr(wr_tab[i][23:16], wr_tab[i][15:8]);
         rd(wr_tab[i][23:16], wr_tab[i][7:0]);
      end
      chk("slaves", {13'h0, sc}, 16'h5);
      for (int i = 0; i < 8; i++) wr(8'h10 + 8'(i), 8'h00);
      wr(8'h00, 8'h01);
      afe <= 1'b1;
      @(posedge core_clk);
      chk("role", {14'h0, pr}, 16'h1);
      foreach (fn_tab[i])
      begin
         wr(8'h10, fn_tab[i][39:32]);
         settle(8'h01);
         chk("active", st, fn_tab[i][31:16]);
         settle(8'h00);
         chk("idle", st, fn_tab[i][15:0]);
      end
      chk("pulses", pulses, 16'h1);
      wr(8'h10, 8'h01);
      wr(8'h11, 8'h0b);
      settle(8'h03);
      chk("swap", st, 16'h6000);
      settle(8'h00);
      wr(8'h01, 8'h01);
      wr(8'h02, 8'h01);
      repeat (3) @(posedge core_clk);
      chk("bus motor", {14'h0, tmo}, 16'h3);
      chk("language", {15'h0, pl}, 16'h1);
      p_rst <= 1'b1;
      repeat (5) @(posedge core_clk);
      p_rst <= 1'b0;
      chk("panel pulse", pulses, 16'h2);
      // Light on with a long timeout first, so the short one must turn it off
      p_act <= 1'b1;
      @(posedge core_clk);
      p_act <= 1'b0;
      wr(8'h04, 8'h01);
      repeat (30) @(posedge core_clk);
      chk("light off", {15'h0, bl}, 16'h0);
      p_act <= 1'b1;
      @(posedge core_clk);
      p_act <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("light on", {15'h0, bl}, 16'h1);
      // Run held through a reset waits for one release
      want <= 8'h01;
      rst_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (30) @(posedge core_clk);
      chk("held run", {15'h0, rf}, 16'h0);
      settle(8'h00);
      settle(8'h01);
      chk("released run", {15'h0, rf}, 16'h1);
      test_done;
   end
endmodule
